// >>> hdl/csdec_params.svh
// constants for the chip select decoder: offsets, fields, resets, timing
// assumes inclusion by bare name from the decoder module, checker and bench
`ifndef CSDEC_PARAMS_SVH
`define CSDEC_PARAMS_SVH
// register word offsets on the plain register port
`define CSDEC_OFS_BASE_A 8'h00
`define CSDEC_OFS_BASE_B 8'h02
`define CSDEC_OFS_BASE_C 8'h04
`define CSDEC_OFS_BASE_D 8'h06
`define CSDEC_OFS_CFG_A 8'h10
`define CSDEC_OFS_CFG_B 8'h12
`define CSDEC_OFS_CFG_C 8'h14
`define CSDEC_OFS_CFG_D 8'h16
`define CSDEC_OFS_STATUS 8'h20
// config register fields
`define CSDEC_CFG_EN 0
`define CSDEC_CFG_RO 1
`define CSDEC_CFG_SIZE_LO 2
`define CSDEC_CFG_SIZE_HI 4
`define CSDEC_CFG_WS_LO 5
`define CSDEC_CFG_WS_HI 8
`define CSDEC_CFG_WIDTH16 9
`define CSDEC_CFG_DRAM 10
`define CSDEC_CFG_SUB_LO 11
`define CSDEC_CFG_SUB_HI 13
`define CSDEC_CFG_ACK 14
// reset values
`define CSDEC_BASE_RST 16'h0000
`define CSDEC_CFG_RST 16'h0000
// wait states 0..13
`define CSDEC_WS_MAX 4'hD
// on-chip register page starting at 0xFFFFF000
`define CSDEC_REG_PAGE 20'hFFFFF
// interrupt acknowledge function code
`define CSDEC_FC_IACK 3'h7
// smallest range, 32K = 2**15; group a smallest is 128K = 2**17
`define CSDEC_MIN_LOG2 15
`define CSDEC_A_MIN_LOG2 17
`endif

// >>> hdl/csdec_pkg.sv
// types for the chip select decoder
// assumes csdec_params.svh on the include path
package csdec_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0] fc;
        logic rd_wr_n;
        logic is_word;
    } csdec_bus_t;
    typedef enum logic [3:0] {
        CSDEC_IDLE = 4'h1,
        CSDEC_WAIT = 4'h2,
        CSDEC_ACK = 4'h4,
        CSDEC_GAP = 4'h8
    } csdec_state_t;
endpackage : csdec_pkg

// >>> hdl/csdec_top.sv
// chip select decoder: eight selects in four groups of two
// assumes processor bus inputs synchronous to clock, registers on plain port
//
// Summary of operation
// - eight selects in four groups of two
// - boot select decodes all but register page and iack cycles until group a enabled
// - then boot select decodes only its range
// - groups c and d may act as dram strobes
// - internal acknowledge after 0 to 13 waits
// - select asserts after address strobe falls
// - groups b-d sizes 32K through 4M
// - group a sizes 128K through 16M
// - each group read-only or read/write
// - no match in function code seven cycles
// - writable sub-area inside read-only range of groups b-d
// - 16-bit to 8-bit port splits in two
// - split uses upper lane, address bit advances
// - boot width pin sampled at reset
// - unmatched access treated as 16-bit
// - boot select skips top register page
// - other selects invalid until enabled
// - write to read-only gives no select, no ack, berr if timeout enabled
// - all configuration registers read back
// - base holds address bits 28 to 14
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "csdec_params.svh"
module csdec_top
    import csdec_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire csdec_bus_t bus,
    input wire logic as_n,
    input wire logic boot_width_pin,
    input wire logic bus_timeout_en,
    output logic [1:0] group_a_select_n,
    output logic [1:0] group_b_select_n,
    output logic [1:0] group_c_select_n,
    output logic [1:0] group_d_select_n,
    output logic [1:0] row_strobe_n,
    output logic [1:0] column_strobe_n,
    output logic dtack_n,
    output logic berr_n,
    output logic addr0_out,
    output logic upper_lane_only,
    output logic port_16bit
);
    // ********************************************
    // configuration registers
    // ********************************************
    logic [15:0] base_q [4];
    logic [15:0] cfg_q [4];
    logic boot_w16_q;
    logic boot_taken_q;
    logic nrst_seen_q;
    csdec_state_t state_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int g = 0; g < 4; g++) begin
                base_q[g] <= `CSDEC_BASE_RST;
                cfg_q[g] <= `CSDEC_CFG_RST;
            end
        end else if (reg_wr) begin
            for (int g = 0; g < 4; g++) begin
                if (reg_addr == `CSDEC_OFS_BASE_A + 8'(2 * g))
                    base_q[g] <= {reg_wdata[15:1], 1'b0};
                if (reg_addr == `CSDEC_OFS_CFG_A + 8'(2 * g))
                    cfg_q[g] <= {1'b0, reg_wdata[14:0]};
            end
        end
    end

    // boot width caught in the first clock after reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nrst_seen_q <= 1'b0;
            boot_w16_q <= 1'b0;
        end else if (!nrst_seen_q) begin
            nrst_seen_q <= 1'b1;
            boot_w16_q <= boot_width_pin;
        end
    end

    // boot select leaves global decode once group a is enabled
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            boot_taken_q <= 1'b0;
        else if (cfg_q[0][`CSDEC_CFG_EN])
            boot_taken_q <= 1'b1;
    end

    // ********************************************
    // register read back
    // ********************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            reg_rdata <= 16'h0000;
        else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            for (int g = 0; g < 4; g++) begin
                if (reg_addr == `CSDEC_OFS_BASE_A + 8'(2 * g))
                    reg_rdata <= base_q[g];
                if (reg_addr == `CSDEC_OFS_CFG_A + 8'(2 * g))
                    reg_rdata <= cfg_q[g];
            end
            if (reg_addr == `CSDEC_OFS_STATUS)
                reg_rdata <= {11'h000, state_q != CSDEC_IDLE, boot_w16_q, boot_taken_q,
                              ~dtack_n, ~berr_n};
        end else
            reg_rdata <= 16'h0000;
    end

    // ********************************************
    // address decode
    // ********************************************
    logic [7:0] hit;
    logic [7:0] hit_rw;
    logic iack;
    logic in_reg_page;
    logic boot_global;

    assign iack = (bus.fc == `CSDEC_FC_IACK);
    assign in_reg_page = (bus.addr[31:12] == `CSDEC_REG_PAGE);
    assign boot_global = !boot_taken_q && !in_reg_page;

    always_comb begin
        hit = 8'h00;
        hit_rw = 8'h00;
        for (int g = 0; g < 4; g++) begin
            int lg;
            int sl;
            logic [28:0] m;
            logic [28:0] ms;
            logic grp_ok;
            logic hi;
            logic wr_ok;
            lg = ((g == 0) ? `CSDEC_A_MIN_LOG2 : `CSDEC_MIN_LOG2)
                 + int'(cfg_q[g][`CSDEC_CFG_SIZE_HI:`CSDEC_CFG_SIZE_LO]);
            if (lg > 24)
                lg = 24;
            sl = `CSDEC_MIN_LOG2 + int'(cfg_q[g][`CSDEC_CFG_SUB_HI:`CSDEC_CFG_SUB_LO]);
            if (sl > lg)
                sl = lg;
            // group window is two ranges wide
            m = ~((29'h00000001 << (lg + 1)) - 29'h00000001);
            ms = ~((29'h00000001 << sl) - 29'h00000001);
            grp_ok = ((bus.addr[28:0] & m) == ({base_q[g][15:1], 14'h0000} & m));
            hi = bus.addr[lg];
            // sub-area counted from range start; ro bit protects the rest
            wr_ok = !cfg_q[g][`CSDEC_CFG_RO]
                    || (g != 0 && ((bus.addr[28:0] & ~m & ~(29'h00000001 << lg) & ms)
                        == 29'h00000000));
            if (cfg_q[g][`CSDEC_CFG_EN] && grp_ok && !iack) begin
                hit[2 * g + int'(hi)] = 1'b1;
                hit_rw[2 * g + int'(hi)] = wr_ok;
            end
        end
        if (boot_global && !iack) begin
            hit[0] = 1'b1;
            hit_rw[0] = 1'b1;
        end
    end

    // ********************************************
    // cycle sequencer
    // ********************************************
    logic [7:0] sel_q;
    logic [3:0] ws_q;
    logic [2:0] g_q;
    logic w16_q;
    logic split_q;
    logic ack_q;
    logic [3:0] ws_cfg;
    logic allowed;
    logic [2:0] gsel;
    logic any_hit;
    logic width16;

    always_comb begin
        gsel = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (hit[i])
                gsel = 3'(i / 2);
    end
    assign any_hit = |hit;
    assign allowed = bus.rd_wr_n || |(hit & hit_rw);
    assign ws_cfg = (cfg_q[gsel[1:0]][`CSDEC_CFG_WS_HI:`CSDEC_CFG_WS_LO] > `CSDEC_WS_MAX)
                    ? `CSDEC_WS_MAX : cfg_q[gsel[1:0]][`CSDEC_CFG_WS_HI:`CSDEC_CFG_WS_LO];
    assign width16 = !any_hit ? 1'b1
                   : (boot_global && hit[0] && !(|hit[7:1])) ? boot_w16_q
                   : cfg_q[gsel[1:0]][`CSDEC_CFG_WIDTH16];

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= CSDEC_IDLE;
            sel_q <= 8'h00;
            ws_q <= 4'h0;
            g_q <= 3'h0;
            w16_q <= 1'b1;
            split_q <= 1'b0;
            ack_q <= 1'b0;
            berr_n <= 1'b1;
        end else begin
            case (state_q)
                CSDEC_IDLE: begin
                    if (!as_n) begin
                        w16_q <= width16;
                        split_q <= !width16 && bus.is_word;
                        g_q <= gsel;
                        if (any_hit && allowed) begin
                            sel_q <= hit & (bus.rd_wr_n ? 8'hFF : hit_rw);
                            ack_q <= cfg_q[gsel[1:0]][`CSDEC_CFG_ACK] || (boot_global && hit[0]);
                            ws_q <= ws_cfg;
                            state_q <= CSDEC_WAIT;
                        end else begin
                            berr_n <= !(any_hit && bus_timeout_en);
                            state_q <= CSDEC_GAP;
                        end
                    end
                end
                CSDEC_WAIT: begin
                    if (as_n) begin
                        sel_q <= 8'h00;
                        state_q <= CSDEC_IDLE;
                    end else if (ws_q != 4'h0)
                        ws_q <= ws_q - 4'h1;
                    else if (split_q)
                        split_q <= 1'b0;
                    else if (ack_q)
                        state_q <= CSDEC_ACK;
                end
                CSDEC_ACK: begin
                    if (as_n) begin
                        sel_q <= 8'h00;
                        state_q <= CSDEC_IDLE;
                    end
                end
                CSDEC_GAP: begin
                    if (as_n) begin
                        berr_n <= 1'b1;
                        state_q <= CSDEC_IDLE;
                    end
                end
                default: state_q <= CSDEC_IDLE;
            endcase
        end
    end

    // second byte cycle: address bit 0 goes high once first byte done
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            addr0_out <= 1'b0;
        else if (state_q == CSDEC_IDLE)
            addr0_out <= bus.addr[0];
        else if (state_q == CSDEC_WAIT && split_q && ws_q == 4'h0)
            addr0_out <= 1'b1;
    end

    assign dtack_n = !(state_q == CSDEC_ACK);
    assign upper_lane_only = !w16_q && state_q != CSDEC_IDLE;
    assign port_16bit = w16_q;

    // ********************************************
    // select outputs, dram strobe option for c and d
    // ********************************************
    logic dram_c;
    logic dram_d;
    assign dram_c = cfg_q[2][`CSDEC_CFG_DRAM];
    assign dram_d = cfg_q[3][`CSDEC_CFG_DRAM];
    assign group_a_select_n = ~sel_q[1:0];
    assign group_b_select_n = ~sel_q[3:2];
    assign group_c_select_n = dram_c ? 2'b11 : ~sel_q[5:4];
    assign group_d_select_n = dram_d ? 2'b11 : ~sel_q[7:6];
    assign row_strobe_n = dram_c ? ~sel_q[5:4] : 2'b11;
    assign column_strobe_n = dram_d ? ~sel_q[7:6] : 2'b11;
endmodule : csdec_top

// >>> verification/csdec_assertions.sv
// port checker for the chip select decoder
// assumes bind onto csdec_top, one clock domain
`timescale 1ns/100ps
`include "csdec_params.svh"
module csdec_assertions
    import csdec_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire csdec_bus_t bus,
    input wire logic as_n,
    input wire logic bus_timeout_en,
    input wire logic [1:0] group_a_select_n,
    input wire logic [1:0] group_b_select_n,
    input wire logic [1:0] group_c_select_n,
    input wire logic [1:0] group_d_select_n,
    input wire logic [1:0] row_strobe_n,
    input wire logic dtack_n,
    input wire logic berr_n
);
// ****
// properties
// ****
logic a_en_q;
logic [7:0] sel;
logic up_page;
assign sel = {group_d_select_n, group_c_select_n, group_b_select_n, group_a_select_n};
assign up_page = bus.addr[31:12] == `CSDEC_REG_PAGE;
// global boot decode ends once group a enabled
always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        a_en_q <= 1'b0;
    end else if (reg_wr && reg_addr == `CSDEC_OFS_CFG_A && reg_wdata[0]) begin
        a_en_q <= 1'b1;
    end
end
default clocking cb @(posedge clock); endclocking
default disable iff (!nrst);
boot_global_a: assert property (
    $fell(as_n) && !a_en_q && !up_page && bus.fc != `CSDEC_FC_IACK
    |=> !group_a_select_n[0] ##1 !dtack_n) else $error("boot select missing");
reg_page_a: assert property (
    $fell(as_n) && !a_en_q && up_page |=> (sel == 8'hFF && dtack_n) [*2])
    else $error("select in register page");
iack_cycle_a: assert property (
    $fell(as_n) && bus.fc == `CSDEC_FC_IACK |=> (sel == 8'hFF && dtack_n) [*2])
    else $error("match in iack cycle");
strobe_release_a: assert property (
    as_n |=> sel == 8'hFF && dtack_n) else $error("select not released");
berr_cause_a: assert property (
    $fell(berr_n) |-> $past(bus_timeout_en) && !$past(bus.rd_wr_n))
    else $error("berr without protected write");
protect_quiet_a: assert property (
    !berr_n |-> dtack_n && sel == 8'hFF) else $error("select on protected write");
dram_mode_a: assert property (
    row_strobe_n != 2'h3 |-> group_c_select_n == 2'h3) else $error("select in dram mode");
rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata outside read slot");
ack_in_cycle_a: assert property (
    !dtack_n |-> !$past(as_n)) else $error("dtack outside bus cycle");
endmodule : csdec_assertions
bind csdec_top csdec_assertions i_chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus(bus), .as_n(as_n), .bus_timeout_en(bus_timeout_en),
    .group_a_select_n(group_a_select_n), .group_b_select_n(group_b_select_n),
    .group_c_select_n(group_c_select_n), .group_d_select_n(group_d_select_n),
    .row_strobe_n(row_strobe_n), .dtack_n(dtack_n), .berr_n(berr_n));

// >>> verification/csdec_mem_model.sv
// external device model: counts selected accesses
// assumes active low selects from the decoder
`timescale 1ns/100ps
module csdec_mem_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] sel_n,
    output logic [7:0] hits
);
logic [7:0] prev_q;
always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        prev_q <= 8'hFF;
        hits <= 8'h00;
    end else begin
        prev_q <= sel_n;
        if (prev_q == 8'hFF && sel_n != 8'hFF) begin
            hits <= hits + 8'h01;
        end
    end
end
endmodule : csdec_mem_model

// >>> verification/tb_top.sv
// bench for the chip select decoder
// assumes csdec_top, its bound checker and the device model
`timescale 1ns/100ps
`include "csdec_params.svh"
module tb_top
    import csdec_pkg::*;
;
// ****
// harness
// ****
logic clock, nrst, reg_wr, reg_rd, as_n, bus_timeout_en;
logic [7:0] reg_addr, hits, sel_v;
logic [15:0] reg_wdata, reg_rdata;
csdec_bus_t bus;
logic [1:0] sa, sb, sc, sd, rs, cs, rs_v;
logic dtack_n, berr_n, addr0_out, upper_lane_only, port_16bit;
logic berr_v, a0f, a0l, ul, p16, bw;
int bad_count, compares, sel_at, dt_at;
csdec_top i_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus), .as_n(as_n),
    .boot_width_pin(bw), .bus_timeout_en(bus_timeout_en), .group_a_select_n(sa),
    .group_b_select_n(sb), .group_c_select_n(sc), .group_d_select_n(sd),
    .row_strobe_n(rs), .column_strobe_n(cs), .dtack_n(dtack_n), .berr_n(berr_n),
    .addr0_out(addr0_out), .upper_lane_only(upper_lane_only), .port_16bit(port_16bit));
csdec_mem_model i_mem (.clock(clock), .nrst(nrst), .sel_n({sd, sc, sb, sa}), .hits(hits));
initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
end
task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
        bad_count++;
        $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
endtask : check
task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
endtask : wr
task rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
    @(posedge clock);
endtask : rd
// bounded bus cycle, released one edge after dtack
task cyc(input logic [31:0] a, input logic [2:0] f, input logic rw, input logic w, input int n);
    int i;
    bus <= {a, f, rw, w};
    as_n <= 1'b0;
    sel_v = 8'hFF;
    rs_v = 2'h3;
    sel_at = -1;
    dt_at = -1;
    berr_v = 1'b1;
    for (i = 0; i < n && dt_at < 0; i++) begin
        @(posedge clock);
        #1;
        if (sel_at < 0 && {sd, sc, sb, sa} != 8'hFF) begin
            sel_at = i;
            a0f = addr0_out;
        end
        sel_v = sel_v & {sd, sc, sb, sa};
        rs_v = rs_v & rs;
        berr_v = berr_v & berr_n;
        a0l = addr0_out;
        ul = upper_lane_only;
        p16 = port_16bit;
        if (dtack_n === 1'b0) dt_at = i;
    end
    @(posedge clock);
    as_n <= 1'b1;
    repeat (2) @(posedge clock);
endtask : cyc
task end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask : end_of_test
// ****
// tests
// ****
initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bus = '0;
    as_n = 1'b1;
    bus_timeout_en = 1'b0;
    bw = 1'b1;
    bad_count = 0;
    compares = 0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    rd(`CSDEC_OFS_CFG_B, 16'h0000);
    rd(8'h3E, 16'h0000);
    cyc(32'h00123456, 3'h5, 1'b1, 1'b1, 8);
    check("boot", {sel_v, dt_at[7:0], ul, p16}, 18'h3F805);
    cyc(32'hFFFFF010, 3'h5, 1'b1, 1'b1, 6);
    check("page", {sel_v, dt_at[7:0]}, 16'hFFFF);
    cyc(32'h00123456, 3'h7, 1'b1, 1'b1, 6);
    check("iack", {sel_v, dt_at[7:0]}, 16'hFFFF);
    $display("test boot done");
    wr(`CSDEC_OFS_BASE_A, 16'h0000);
    wr(`CSDEC_OFS_CFG_A, 16'h4241);
    rd(`CSDEC_OFS_CFG_A, 16'h4241);
    cyc(32'h00300000, 3'h5, 1'b1, 1'b1, 8);
    check("unmatched", {sel_v, dt_at[7:0], p16}, 17'h1FFFF);
    cyc(32'h00020000, 3'h5, 1'b1, 1'b1, 20);
    check("group_a1", {sel_v, dt_at[7:0] - sel_at[7:0]}, 16'hFD03);
    $display("test group a done");
    bus_timeout_en <= 1'b1;
    wr(`CSDEC_OFS_BASE_B, 16'h0200);
    wr(`CSDEC_OFS_CFG_B, 16'h41A7);
    rd(`CSDEC_OFS_BASE_B, 16'h0200);
    cyc(32'h00418000, 3'h5, 1'b0, 1'b0, 8);
    check("ro_write", {sel_v, dt_at[7:0], berr_v}, 17'h1FFFE);
    cyc(32'h00418000, 3'h5, 1'b1, 1'b1, 40);
    check("split", {sel_v, dt_at[7:0] - sel_at[7:0], a0f, a0l, ul}, 19'h7B87B);
    cyc(32'h00400000, 3'h5, 1'b0, 1'b0, 40);
    check("sub_write", {sel_v, dt_at[7:0] - sel_at[7:0], berr_v}, 17'h1F61D);
    $display("test group b done");
    wr(`CSDEC_OFS_BASE_C, 16'h0400);
    wr(`CSDEC_OFS_CFG_C, 16'h4601);
    cyc(32'h00800000, 3'h5, 1'b1, 1'b1, 10);
    check("dram", {sel_v, rs_v}, 10'h3FE);
    check("cas", cs, 2'h3);
    check("hits", hits, 8'h04);
    $display("test group c done");
    nrst <= 1'b0;
    bw <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    cyc(32'h00123456, 3'h5, 1'b1, 1'b0, 8);
    check("boot8", {sel_v, dt_at[7:0], ul, p16}, 18'h3F806);
    $display("test boot width done");
    end_of_test();
end
endmodule : tb_top
